/* File: core/float_format_convert.sv */
// Purpose: Native/IEEE single float conversion and carry arithmetic.
// Assumes: All inputs synchronous to MCLK_IN; one request per cycle.
// Notes: Results appear in registers one clock after acceptance.
//
// Behaviour
// [RL1] Native word: 8-bit two's complement exponent, sign, 23-bit fraction.
// [RL2] Native mantissa is two's complement, hidden bit is inverse of sign.
// [RL3] Native exponent -128 means zero; produced zero has sign, fraction 0.
// [RL4] Non-zero native value is 2^e times 01.f or 10.f by sign.
// [RL5] IEEE word: sign on top, exponent biased by 127, 23-bit magnitude.
// [RL6] IEEE normal exponent gives (-1)^s times 2^(e-127) times 1.f.
// [RL7] IEEE exponent 0 zero or denormal; 255 infinity or NaN.
// [RL8] Add-with-carry and subtract-with-borrow fold the carry into results.
// [RL9] Carry follows arithmetic, shifts and rotates; software may write it.
// [RL10] Saturation mode loads limit values on overflow, else result wraps.
// [RL11] 32-bit integers, 24-bit mantissa, eight 8-bit extension registers.
// [RL12] One operand per cycle; converted word registered one clock later.
`timescale 1ns/1ns
`default_nettype none
`include "float_cfg.svh"
module float_format_convert #(
    parameter int EXT_REGS = `EXT_REGS,
    parameter int EXT_BITS = `EXT_BITS
) (
    input wire logic MCLK_IN,
    input wire logic RST_N_IN,
    input wire logic CONV_VALID_IN,
    input wire float_pkg::conv_dir_e CONV_DIR_IN,
    input wire float_pkg::word_t CONV_WORD_IN,
    output logic CONV_VALID_OUT,
    output float_pkg::word_t CONV_WORD_OUT,
    output float_pkg::class_s CONV_CLASS_OUT,
    input wire logic ALU_VALID_IN,
    input wire float_pkg::alu_op_e ALU_OP_IN,
    input wire float_pkg::word_t ALU_A_IN,
    input wire float_pkg::word_t ALU_B_IN,
    output logic ALU_VALID_OUT,
    output float_pkg::word_t ALU_RESULT_OUT,
    output logic ALU_OVERFLOW_OUT,
    input wire logic STATUS_WR_IN,
    input wire logic STATUS_CARRY_IN,
    input wire logic OVERFLOW_SATURATE_MODE_IN,
    output logic CARRY_OUT,
    input wire logic EXT_WR_IN,
    input wire logic [$clog2(EXT_REGS)-1:0] EXT_IDX_IN,
    input wire logic [EXT_BITS-1:0] EXT_BITS_IN,
    output logic [EXT_BITS-1:0] EXT_BITS_OUT
);
    import float_pkg::*;

    // --------------------
    // Elaboration checks
    // --------------------

    if (EXT_REGS < 2 || (EXT_REGS & (EXT_REGS - 1)) != 0) begin : g_bad_regs
        $error("EXT_REGS must be a power of two of at least 2.");
    end
    if (EXT_BITS < 1) begin : g_bad_bits
        $error("EXT_BITS must be at least 1.");
    end

    // --------------------
    // Native to IEEE
    // --------------------

    logic nat_sign;
    logic [`FRAC_W-1:0] nat_frac;
    logic signed [9:0] nat_exp;
    logic signed [9:0] n2i_exp;
    logic signed [9:0] n2i_bexp;
    logic [`FRAC_W-1:0] n2i_frac;
    word_t n2i_word;
    class_s n2i_class;

    always_comb begin
        nat_exp = {{2{CONV_WORD_IN[`NAT_EXP_MSB]}},
                   CONV_WORD_IN[`NAT_EXP_MSB:`NAT_EXP_LSB]}; // RL1
        nat_sign = CONV_WORD_IN[`NAT_SIGN_BIT]; // RL1
        nat_frac = CONV_WORD_IN[`FRAC_W-1:0]; // RL1
        n2i_exp = nat_exp;
        n2i_frac = nat_frac;
        n2i_word = '0;
        n2i_class = '0;
        // Magnitude of 01.f is 1.f; of 10.f is 2 - 0.f.
        if (nat_sign && nat_frac == '0) begin
            n2i_exp = nat_exp + 10'sh001; // RL4
            n2i_frac = '0;
        end else if (nat_sign) begin
            n2i_frac = '0 - nat_frac; // RL2
        end
        n2i_bexp = n2i_exp + `IEEE_BIAS; // RL6
        if (CONV_WORD_IN[`NAT_EXP_MSB:`NAT_EXP_LSB] == `NAT_ZERO_EXP) begin
            n2i_word = '0; // RL3
            n2i_class.is_zero = 1'b1;
        end else if (n2i_bexp >= `IEEE_EXP_TOP) begin
            // Only -2^128 lands here; it has no finite IEEE form.
            n2i_word = {nat_sign, `IEEE_EXP_ALL, {`FRAC_W{1'b0}}}; // RL7
        end else if (n2i_bexp == 10'sh000) begin
            // Exponent -127 becomes denormal; the last bit is dropped.
            n2i_word = {nat_sign, `IEEE_EXP_NONE,
                        1'b1, n2i_frac[`FRAC_W-1:1]}; // RL7
        end else begin
            n2i_word = {nat_sign, n2i_bexp[7:0], n2i_frac}; // RL5
        end
    end

    // --------------------
    // IEEE to native
    // --------------------

    logic ieee_sign;
    logic [7:0] ieee_exp;
    logic [`FRAC_W-1:0] ieee_frac;
    logic signed [9:0] i2n_exp;
    logic signed [9:0] i2n_exp_dec;
    logic [`FRAC_W-1:0] i2n_frac;
    logic i2n_pack;
    word_t i2n_word;
    class_s i2n_class;

    always_comb begin
        ieee_sign = CONV_WORD_IN[`IEEE_SIGN_BIT]; // RL5
        ieee_exp = CONV_WORD_IN[`IEEE_EXP_MSB:`IEEE_EXP_LSB]; // RL5
        ieee_frac = CONV_WORD_IN[`FRAC_W-1:0]; // RL5
        i2n_exp = {2'b00, ieee_exp} - `IEEE_BIAS; // RL6
        i2n_frac = ieee_frac;
        i2n_pack = 1'b0;
        i2n_word = `NAT_ZERO_WORD;
        i2n_class = '0;
        if (ieee_exp == `IEEE_EXP_ALL) begin
            if (ieee_frac != '0) begin
                // A NaN passes through untouched.
                i2n_word = CONV_WORD_IN; // RL7
                i2n_class.is_nan = 1'b1;
            end else begin
                i2n_word = ieee_sign ? `NAT_MAX_NEG : `NAT_MAX_POS; // RL7
                i2n_class.is_inf = 1'b1;
            end
        end else if (ieee_exp == `IEEE_EXP_NONE) begin
            if (ieee_frac == '0) begin
                i2n_word = `NAT_ZERO_WORD; // RL7
                i2n_class.is_zero = 1'b1;
            end else begin
                i2n_class.is_denorm = 1'b1;
                // 2^-126 * 0.1g is 2^-127 * 1.g; smaller values underflow.
                if (ieee_frac[`FRAC_W-1]) begin
                    i2n_exp = `NAT_MIN_EXP; // RL7
                    i2n_frac = {ieee_frac[`FRAC_W-2:0], 1'b0};
                    i2n_pack = 1'b1;
                end
            end
        end else begin
            i2n_pack = 1'b1; // RL6
        end
        i2n_exp_dec = i2n_exp - 10'sh001;
        if (i2n_pack) begin
            if (!ieee_sign) begin
                i2n_word = {i2n_exp[7:0], 1'b0, i2n_frac}; // RL4
            end else if (i2n_frac != '0) begin
                i2n_word = {i2n_exp[7:0], 1'b1, ~i2n_frac + 23'h1}; // RL2
            end else if (i2n_exp != `NAT_MIN_EXP) begin
                // -1.0 * 2^e is 10.0 * 2^(e-1).
                i2n_word = {i2n_exp_dec[7:0], 1'b1, {`FRAC_W{1'b0}}}; // RL4
            end else begin
                i2n_word = `NAT_ZERO_WORD; // RL3
            end
        end
    end

    // --------------------
    // Conversion result register
    // --------------------

    word_t conv_word_reg;
    word_t conv_word_next;
    class_s conv_class_reg;
    class_s conv_class_next;
    logic conv_valid_reg;
    logic conv_valid_next;

    always_comb begin
        conv_valid_next = CONV_VALID_IN; // RL12
        conv_word_next = conv_word_reg;
        conv_class_next = conv_class_reg;
        if (CONV_VALID_IN) begin
            if (CONV_DIR_IN == TO_NATIVE) begin
                conv_word_next = i2n_word; // RL12
                conv_class_next = i2n_class;
            end else begin
                conv_word_next = n2i_word; // RL12
                conv_class_next = n2i_class;
            end
        end
    end

    always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            conv_valid_reg <= 1'b0;
            conv_word_reg <= '0;
            conv_class_reg <= '0;
        end else begin
            conv_valid_reg <= conv_valid_next;
            conv_word_reg <= conv_word_next;
            conv_class_reg <= conv_class_next;
        end
    end

    assign CONV_VALID_OUT = conv_valid_reg;
    assign CONV_WORD_OUT = conv_word_reg;
    assign CONV_CLASS_OUT = conv_class_reg;

    // --------------------
    // Integer arithmetic and status carry
    // --------------------

    alu_carry_if alu_bus ();

    logic carry_reg;
    logic carry_next;
    word_t alu_result_reg;
    word_t alu_result_next;
    logic alu_ovf_reg;
    logic alu_ovf_next;
    logic alu_valid_reg;
    logic alu_valid_next;

    assign alu_bus.op = ALU_OP_IN;
    assign alu_bus.a = ALU_A_IN;
    assign alu_bus.b = ALU_B_IN;
    assign alu_bus.carry_in = carry_reg; // RL8
    assign alu_bus.sat_mode = OVERFLOW_SATURATE_MODE_IN; // RL10

    carry_alu u_carry_alu (
        .bus(alu_bus.alu)
    );

    always_comb begin
        alu_valid_next = ALU_VALID_IN;
        alu_result_next = alu_result_reg;
        alu_ovf_next = alu_ovf_reg;
        carry_next = carry_reg;
        if (ALU_VALID_IN) begin
            alu_result_next = alu_bus.result; // RL11
            alu_ovf_next = alu_bus.overflow;
            carry_next = alu_bus.carry_out; // RL9
        end
        // A direct status write is the later instruction, so it wins.
        if (STATUS_WR_IN) begin
            carry_next = STATUS_CARRY_IN; // RL9
        end
    end

    always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            alu_valid_reg <= 1'b0;
            alu_result_reg <= '0;
            alu_ovf_reg <= 1'b0;
            carry_reg <= 1'b0;
        end else begin
            alu_valid_reg <= alu_valid_next;
            alu_result_reg <= alu_result_next;
            alu_ovf_reg <= alu_ovf_next;
            carry_reg <= carry_next;
        end
    end

    assign ALU_VALID_OUT = alu_valid_reg;
    assign ALU_RESULT_OUT = alu_result_reg;
    assign ALU_OVERFLOW_OUT = alu_ovf_reg;
    assign CARRY_OUT = carry_reg;

    // --------------------
    // Extended-precision mantissa bits
    // --------------------

    logic [EXT_BITS-1:0] ext_mem_reg [EXT_REGS];
    logic [EXT_BITS-1:0] ext_mem_next [EXT_REGS];
    logic [EXT_BITS-1:0] ext_rd_reg;
    logic [EXT_BITS-1:0] ext_rd_next;

    for (genvar i = 0; i < EXT_REGS; i++) begin : g_ext
        always_comb begin
            ext_mem_next[i] = ext_mem_reg[i];
            if (EXT_WR_IN && EXT_IDX_IN == i) begin
                ext_mem_next[i] = EXT_BITS_IN; // RL11
            end
        end

        always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
            if (!RST_N_IN) begin
                ext_mem_reg[i] <= '0;
            end else begin
                ext_mem_reg[i] <= ext_mem_next[i];
            end
        end
    end

    // The read shows the stored value, not one being written this cycle.
    always_comb begin
        ext_rd_next = ext_mem_reg[EXT_IDX_IN]; // RL11
    end

    always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            ext_rd_reg <= '0;
        end else begin
            ext_rd_reg <= ext_rd_next;
        end
    end

    assign EXT_BITS_OUT = ext_rd_reg;

endmodule : float_format_convert
`default_nettype wire

/* File: shared/float_cfg.svh */
// Purpose: Field positions, special words and sizes of the float formats.
// Assumes: Included by bare name; definitions only.
// Notes: Native word is exponent, sign, fraction from the top down.
`ifndef FLOAT_CFG_SVH
`define FLOAT_CFG_SVH

`define WORD_W 32
`define FRAC_W 23
`define NAT_EXP_MSB 31
`define NAT_EXP_LSB 24
`define NAT_SIGN_BIT 23
`define NAT_ZERO_EXP 8'h80
`define NAT_ZERO_WORD 32'h80000000
`define NAT_MAX_POS 32'h7f7fffff
`define NAT_MAX_NEG 32'h7f800000
`define NAT_MIN_EXP 10'sh381
`define IEEE_SIGN_BIT 31
`define IEEE_EXP_MSB 30
`define IEEE_EXP_LSB 23
`define IEEE_BIAS 10'sh07f
`define IEEE_EXP_TOP 10'sh0ff
`define IEEE_EXP_ALL 8'hff
`define IEEE_EXP_NONE 8'h00
`define SAT_POS 32'h7fffffff
`define SAT_NEG 32'h80000000
`define SHIFT_W 5
`define EXT_REGS 8
`define EXT_BITS 8

`endif

/* File: shared/float_pkg.sv */
// Purpose: Types shared by the format converter and its integer unit.
// Assumes: Nothing beyond the synthesizable subset.
// Notes: Operation codes are plain selects, not states.
package float_pkg;

    typedef logic [31:0] word_t;

    typedef enum logic [2:0] {
        ADD_OP = 3'h0,
        ADD_WITH_CARRY_OP = 3'h1,
        SUB_OP = 3'h2,
        SUBTRACT_WITH_BORROW_OP = 3'h3,
        SHIFT_LEFT_OP = 3'h4,
        SHIFT_RIGHT_OP = 3'h5,
        ROTATE_LEFT_OP = 3'h6,
        ROTATE_RIGHT_OP = 3'h7
    } alu_op_e;

    typedef enum logic {
        TO_IEEE = 1'b0,
        TO_NATIVE = 1'b1
    } conv_dir_e;

    typedef struct packed {
        logic is_zero;
        logic is_denorm;
        logic is_inf;
        logic is_nan;
    } class_s;

endpackage : float_pkg

/* File: shared/alu_carry_if.sv */
// Purpose: Bundle between the converter top and its carry arithmetic unit.
// Assumes: Both ends in the same clock domain; the unit is combinational.
// Notes: The top drives operands, the unit answers in the same cycle.
`timescale 1ns/1ns
`default_nettype none
interface alu_carry_if;
    import float_pkg::*;
    alu_op_e op;
    word_t a;
    word_t b;
    logic carry_in;
    logic sat_mode;
    word_t result;
    logic carry_out;
    logic overflow;

    modport core (
        output op, a, b, carry_in, sat_mode,
        input result, carry_out, overflow
    );
    modport alu (
        input op, a, b, carry_in, sat_mode,
        output result, carry_out, overflow
    );
endinterface : alu_carry_if
`default_nettype wire

/* File: core/carry_alu.sv */
// Purpose: 32-bit add, subtract, shift and rotate with a carry bit.
// Assumes: Shift and rotate counts come from the low bits of operand b.
// Notes: Purely combinational; the caller registers result and carry.
`timescale 1ns/1ns
`default_nettype none
`include "float_cfg.svh"
module carry_alu (
    alu_carry_if.alu bus
);
    import float_pkg::*;

    logic [32:0] sum;
    logic [32:0] sh;
    logic [63:0] rot;
    logic [`SHIFT_W-1:0] n;
    word_t res;
    logic cout;
    logic ovf;

    always_comb begin
        n = bus.b[`SHIFT_W-1:0];
        sum = '0;
        sh = '0;
        rot = '0;
        res = bus.a;
        cout = bus.carry_in;
        ovf = 1'b0;
        case (bus.op)
            ADD_OP, ADD_WITH_CARRY_OP: begin
                sum = {1'b0, bus.a} + {1'b0, bus.b};
                if (bus.op == ADD_WITH_CARRY_OP) begin
                    sum = sum + 33'(bus.carry_in); // RL8
                end
                res = sum[31:0];
                cout = sum[32]; // RL9
                ovf = (bus.a[31] == bus.b[31]) && (res[31] != bus.a[31]);
            end
            SUB_OP, SUBTRACT_WITH_BORROW_OP: begin
                sum = {1'b0, bus.a} - {1'b0, bus.b};
                if (bus.op == SUBTRACT_WITH_BORROW_OP) begin
                    sum = sum - 33'(bus.carry_in); // RL8
                end
                res = sum[31:0];
                // Carry holds the borrow so a high-word step can chain.
                cout = sum[32]; // RL9
                ovf = (bus.a[31] != bus.b[31]) && (res[31] != bus.a[31]);
            end
            SHIFT_LEFT_OP: begin
                sh = {1'b0, bus.a} << n;
                res = sh[31:0];
                if (n != '0) begin
                    cout = sh[32]; // RL9
                end
            end
            SHIFT_RIGHT_OP: begin
                sh = {bus.a, 1'b0} >> n;
                res = sh[32:1];
                if (n != '0) begin
                    cout = sh[0]; // RL9
                end
            end
            ROTATE_LEFT_OP: begin
                rot = {bus.a, bus.a} << n;
                res = rot[63:32];
                cout = res[0]; // RL9
            end
            ROTATE_RIGHT_OP: begin
                rot = {bus.a, bus.a} >> n;
                res = rot[31:0];
                cout = res[31]; // RL9
            end
            default: begin
                res = bus.a;
            end
        endcase
        // A wrapped sign shows the true result had the other sign.
        if (ovf && bus.sat_mode) begin
            res = res[31] ? `SAT_POS : `SAT_NEG; // RL10
        end
    end

    assign bus.result = res;
    assign bus.carry_out = cout;
    assign bus.overflow = ovf;

endmodule : carry_alu
`default_nettype wire

/* File: tb/core_regfile_model.sv */
// Purpose: Core register pair that collects results for wide arithmetic.
// Assumes: Results arrive low word first, high word next.
// Notes: Each valid result shifts the pair down by one word.
`timescale 1ns/1ns
`default_nettype none
module core_regfile_model (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic valid_in,
    input wire float_pkg::word_t word_in,
    output logic [63:0] pair_out
);
    import float_pkg::*;
    // ----------
    // Result capture
    // ----------
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pair_out <= 64'h0;
        end else if (valid_in) begin
            pair_out <= {word_in, pair_out[63:32]};
        end
    end
endmodule : core_regfile_model
`default_nettype wire

/* File: tb/float_format_convert_chk.sv */
// Purpose: Temporal checks on the converter and carry unit ports.
// Assumes: One clock domain, reset active low.
// Notes: Saturation is checked on plain adds only.
`timescale 1ns/1ns
`default_nettype none
module float_format_convert_chk (
    input wire logic MCLK_IN,
    input wire logic RST_N_IN,
    input wire logic CONV_VALID_IN,
    input wire float_pkg::conv_dir_e CONV_DIR_IN,
    input wire float_pkg::word_t CONV_WORD_IN,
    input wire logic CONV_VALID_OUT,
    input wire float_pkg::word_t CONV_WORD_OUT,
    input wire logic ALU_VALID_IN,
    input wire float_pkg::alu_op_e ALU_OP_IN,
    input wire float_pkg::word_t ALU_A_IN,
    input wire float_pkg::word_t ALU_B_IN,
    input wire logic ALU_VALID_OUT,
    input wire float_pkg::word_t ALU_RESULT_OUT,
    input wire logic STATUS_WR_IN,
    input wire logic STATUS_CARRY_IN,
    input wire logic OVERFLOW_SATURATE_MODE_IN,
    input wire logic CARRY_OUT
);
    import float_pkg::*;
    // ----------
    // Helpers
    // ----------
    word_t sum;
    word_t sat_word;
    logic to_nat;
    logic nat_sign;
    logic sat_add;
    logic plain_add;
    assign sum = ALU_A_IN + ALU_B_IN;
    assign sat_word = ALU_A_IN[31] ? 32'h80000000 : 32'h7fffffff;
    assign nat_sign = CONV_WORD_IN[23];
    assign to_nat = CONV_VALID_IN && CONV_DIR_IN == TO_NATIVE;
    assign plain_add = ALU_VALID_IN && ALU_OP_IN == ADD_OP;
    assign sat_add = plain_add && OVERFLOW_SATURATE_MODE_IN
        && ALU_A_IN[31] == ALU_B_IN[31] && sum[31] != ALU_A_IN[31];
    default clocking cb @(posedge MCLK_IN); endclocking
    default disable iff (!RST_N_IN);
    // ----------
    // Assertions
    // ----------
    a_conv_answer:
    assert property (CONV_VALID_IN |=> CONV_VALID_OUT)
        else $error("conversion answer missing");
    a_conv_hold:
    assert property (!CONV_VALID_IN |=> !CONV_VALID_OUT && $stable(CONV_WORD_OUT))
        else $error("conversion output moved without request");
    a_native_zero:
    assert property (to_nat && CONV_WORD_IN[30:0] == 31'h0
        |=> CONV_WORD_OUT == 32'h80000000) else $error("zero not mapped");
    a_ieee_zero:
    assert property (CONV_VALID_IN && CONV_DIR_IN == TO_IEEE
        && CONV_WORD_IN[31:24] == 8'h80 |=> CONV_WORD_OUT == 32'h0)
        else $error("native zero not mapped");
    a_nan_kept:
    assert property (to_nat && &CONV_WORD_IN[30:23] && |CONV_WORD_IN[22:0]
        |=> CONV_WORD_OUT == $past(CONV_WORD_IN)) else $error("nan altered");
    a_sign_moved:
    assert property (CONV_VALID_IN && CONV_DIR_IN == TO_IEEE
        && CONV_WORD_IN[31:24] != 8'h80 |=> CONV_WORD_OUT[31] == $past(nat_sign))
        else $error("sign misplaced");
    a_alu_answer:
    assert property (ALU_VALID_IN |=> ALU_VALID_OUT)
        else $error("arithmetic answer missing");
    a_sat_limit:
    assert property (sat_add |=> ALU_RESULT_OUT == $past(sat_word))
        else $error("saturation value wrong");
    a_add_wrap:
    assert property (plain_add && !OVERFLOW_SATURATE_MODE_IN
        |=> ALU_RESULT_OUT == $past(sum)) else $error("wrapped sum wrong");
    a_carry_fold:
    assert property (ALU_VALID_IN && ALU_OP_IN == ADD_WITH_CARRY_OP
        && !OVERFLOW_SATURATE_MODE_IN
        |=> ALU_RESULT_OUT == $past(sum) + $past(CARRY_OUT))
        else $error("carry not added");
    a_status_load:
    assert property (STATUS_WR_IN |=> CARRY_OUT == $past(STATUS_CARRY_IN))
        else $error("status write lost");
    a_carry_still:
    assert property (!ALU_VALID_IN && !STATUS_WR_IN |=> $stable(CARRY_OUT))
        else $error("carry moved while idle");
    c_to_native: cover property (to_nat ##1 CONV_VALID_OUT);
    c_saturate: cover property (sat_add);
    c_chain: cover property (ALU_VALID_IN && ALU_OP_IN == ADD_WITH_CARRY_OP
        && CARRY_OUT);
endmodule : float_format_convert_chk
`default_nettype wire

/* File: tb/float_format_convert_tb_top.sv */
// Purpose: Self-checking bench for format conversion and carry arithmetic.
// Assumes: Inputs change at the falling edge only.
// Notes: A reference model predicts every result except the to-IEEE class, one clock ahead.
`timescale 1ns/1ns
`default_nettype none
module float_format_convert_tb_top;
    import float_pkg::*;
    logic clk, rst_n, cv, av, sw, sc, mode, ew, cvo, avo, ovo, co, mc;
    conv_dir_e dir;
    alu_op_e op;
    word_t cw, a, b, cwo, res;
    class_s cls;
    logic [2:0] ei;
    logic [7:0] eb, ebo;
    logic [7:0] ext_m [8];
    logic [63:0] pair;
    int miscompares = 0;
    int checked = 0;
    integer seed = 32'h4ed3ee4b;
    word_t dvec [20] = '{32'h80000000, 32'h80123456, 32'h00000000,
        32'h00800000, 32'h81000000, 32'h7f800000, 32'h7f7fffff, 32'h01c00000,
        32'h3f800000, 32'hbf800000, 32'h7f800000, 32'hff800000, 32'h7fc00001,
        32'h00000000, 32'h80000000, 32'h00400000, 32'h00200000, 32'h80800000,
        32'h80400000, 32'hc0400000};
    logic [67:0] atab [11] = '{68'h0_ffffffff_00000001,
        68'h1_00000001_00000002, 68'h2_00000000_00000001,
        68'h3_00000005_00000001, 68'h8_7fffffff_00000001,
        68'ha_80000000_00000001, 68'h0_7fffffff_00000001,
        68'h4_80000001_00000000, 68'h5_00000003_00000001,
        68'h6_80000001_00000004, 68'h7_00000001_00000001};

    float_format_convert #(.EXT_REGS(8), .EXT_BITS(8)) DUT (
        .MCLK_IN(clk), .RST_N_IN(rst_n), .CONV_VALID_IN(cv),
        .CONV_DIR_IN(dir), .CONV_WORD_IN(cw), .CONV_VALID_OUT(cvo),
        .CONV_WORD_OUT(cwo), .CONV_CLASS_OUT(cls), .ALU_VALID_IN(av),
        .ALU_OP_IN(op), .ALU_A_IN(a), .ALU_B_IN(b), .ALU_VALID_OUT(avo),
        .ALU_RESULT_OUT(res), .ALU_OVERFLOW_OUT(ovo), .STATUS_WR_IN(sw),
        .STATUS_CARRY_IN(sc), .OVERFLOW_SATURATE_MODE_IN(mode),
        .CARRY_OUT(co), .EXT_WR_IN(ew), .EXT_IDX_IN(ei), .EXT_BITS_IN(eb),
        .EXT_BITS_OUT(ebo));
    core_regfile_model u_core (.clk_in(clk), .rst_n_in(rst_n),
        .valid_in(avo), .word_in(res), .pair_out(pair));

    always #5 clk = ~clk;

    // ----------
    // Reference model
    // ----------
    function automatic word_t to_ieee(input word_t w);
        int e;
        logic [22:0] g;
        e = $signed(w[31:24]);
        g = w[23] ? -w[22:0] : w[22:0];
        if (e == -128) return 32'h0;
        if (w[23] && w[22:0] == 23'h0) e++;
        e += 127;
        if (e >= 255) return 32'hff800000;
        if (e <= 0) return {w[23], 8'h00, 1'b1, g[22:1]};
        return {w[23], e[7:0], g};
    endfunction : to_ieee

    function automatic word_t to_nat(input word_t w);
        int e;
        logic [22:0] g;
        e = w[30:23];
        g = w[22:0];
        if (e == 255) return g != 0 ? w : (w[31] ? 32'h7f800000 : 32'h7f7fffff);
        if (e == 0 && !g[22]) return 32'h80000000;
        if (e == 0) g = {g[21:0], 1'b0};
        e -= 127;
        if (!w[31]) return {e[7:0], 1'b0, g};
        if (g != 0) return {e[7:0], 1'b1, -g};
        if (e == -127) return 32'h80000000;
        return {e[7:0] - 8'h01, 1'b1, 23'h0};
    endfunction : to_nat

    task automatic alu_model(output word_t r, output logic ov);
        logic [32:0] s;
        logic [4:0] n;
        n = b[4:0];
        ov = 1'b0;
        s = 33'h0;
        case (op)
            ADD_OP, ADD_WITH_CARRY_OP: begin
                s = a + b + (op == ADD_WITH_CARRY_OP && mc);
                ov = a[31] == b[31] && s[31] != a[31];
                mc = s[32];
            end
            SUB_OP, SUBTRACT_WITH_BORROW_OP: begin
                s = {1'b0, a} - b - (op == SUBTRACT_WITH_BORROW_OP && mc);
                ov = a[31] != b[31] && s[31] != a[31];
                mc = s[32];
            end
            SHIFT_LEFT_OP: begin
                s[31:0] = a << n;
                if (n != 0) mc = a[32 - n];
            end
            SHIFT_RIGHT_OP: begin
                s[31:0] = a >> n;
                if (n != 0) mc = a[n - 1];
            end
            ROTATE_LEFT_OP: begin
                s[31:0] = (a << n) | (a >> (32 - n));
                mc = s[0];
            end
            default: begin
                s[31:0] = (a >> n) | (a << (32 - n));
                mc = s[31];
            end
        endcase
        r = s[31:0];
        if (ov && mode) r = a[31] ? 32'h80000000 : 32'h7fffffff;
    endtask : alu_model

    // ----------
    // Checking and driving
    // ----------
    task automatic chk_word(input word_t g, input word_t e);
        checked++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected at %0t: word %h, model %h", $time, g, e);
        end
    endtask : chk_word

    task automatic chk_bit(input logic g, input logic e);
        checked++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected at %0t: flag %b, model %b", $time, g, e);
        end
    endtask : chk_bit

    task automatic step();
        word_t wx, ar;
        logic ov, cvx, avx;
        logic [7:0] ee;
        conv_dir_e dx;
        class_s cl;
        cvx = cv;
        avx = av;
        dx = dir;
        wx = dir == TO_NATIVE ? to_nat(cw) : to_ieee(cw);
        cl = {{2{cw[30:23] == 8'h00}}, {2{&cw[30:23]}}}
            & {2{~|cw[22:0], |cw[22:0]}};
        if (av) alu_model(ar, ov);
        if (sw) mc = sc;
        ee = ext_m[ei];
        if (ew) ext_m[ei] = eb;
        @(negedge clk);
        chk_bit(cvo, cvx);
        if (cvx) chk_word(cwo, wx);
        if (cvx && dx == TO_NATIVE) chk_word(32'(cls), 32'(cl));
        chk_bit(avo, avx);
        if (avx) chk_word(res, ar);
        if (avx) chk_bit(ovo, ov);
        chk_bit(co, mc);
        chk_word(32'(ebo), 32'(ee));
    endtask : step

    task automatic do_reset();
        rst_n = 1'b0;
        {cv, av, sw, ew} = 4'h0;
        mc = 1'b0;
        foreach (ext_m[i]) ext_m[i] = 8'h00;
        repeat (10) @(negedge clk);
        chk_word(cwo, 32'h0);
        chk_bit(co, 1'b0);
        rst_n = 1'b1;
    endtask : do_reset

    task automatic rnd(input int n);
        word_t r;
        repeat (n) begin
            r = $random(seed);
            cv = r[0];
            dir = conv_dir_e'(r[1]);
            av = r[2];
            op = alu_op_e'(r[5:3]);
            sw = r[8:6] == 3'h0;
            sc = r[9];
            mode = r[10];
            ew = r[11];
            ei = r[14:12];
            eb = r[22:15];
            cw = $random(seed);
            a = $random(seed);
            b = $random(seed);
            if (r[25:23] == 3'h0) cw[30:23] = {8{r[26]}};
            step();
        end
    endtask : rnd

    task automatic complete_run();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : complete_run

    initial begin
        #100000;
        miscompares++;
        complete_run();
    end

    initial begin
        {clk, sc, mode, ei, eb, cw, a, b} = '0;
        dir = TO_IEEE;
        op = ADD_OP;
        do_reset();
        foreach (dvec[i]) begin
            cv = 1'b1;
            dir = conv_dir_e'(i >= 8);
            cw = dvec[i];
            step();
        end
        cv = 1'b0;
        av = 1'b1;
        foreach (atab[i]) begin
            mode = atab[i][67];
            op = alu_op_e'(atab[i][66:64]);
            a = atab[i][63:32];
            b = atab[i][31:0];
            step();
            if (i == 2) chk_word(pair[63:32], 32'h00000004);
            if (i == 4) chk_word(pair[31:0], 32'hffffffff);
            if (i == 4) chk_word(pair[63:32], 32'h00000003);
        end
        rnd(400);
        do_reset();
        rnd(100);
        complete_run();
    end
endmodule : float_format_convert_tb_top

bind float_format_convert float_format_convert_chk u_chk (.*);
`default_nettype wire
